// ===== bench/tb_top.sv
// Purpose: self-checking bench for the logic error inquiry bank
// Assumes: counts shortened through the design parameters
// Notes: expected bytes are built from the flag layout, never read back
`timescale 1ns/1ps
`include "lesi_params.svh"

module tb_top;
  import lesi_pkg::*;
  localparam int MIN_CYC = 5;
  localparam int TIMEOUT_CYC = 50;
  localparam logic [15:0] AVAIL = `LESI_BASE_ADDR + `LESI_OFS_AVAIL;
  localparam logic [15:0] FLAGS = `LESI_BASE_ADDR + `LESI_OFS_FLAGS;
  localparam logic [31:0] GSTAT_SET = 32'h1 << `LESI_GSTAT_TRIG_BIT;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  lesi_req_s req = '0;
  logic [7:0] rdata;
  logic inquiry_ready = 1'h0;
  logic fw_image_absent = 1'h0;
  logic fw_load_failed = 1'h0;
  logic line_trigger_input = 1'h0;
  logic programmable_mode = 1'h0;
  logic line_trigger_accept;
  logic [31:0] gstat_trig_bits;
  int n_errors = 0;
  int n_compared = 0;

  always #4 core_clk = ~core_clk;

  lesi_inquiry #(.MIN_CYC(MIN_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .req(req),
    .rdata(rdata),
    .inquiry_ready(inquiry_ready),
    .fw_image_absent(fw_image_absent),
    .fw_load_failed(fw_load_failed),
    .line_trigger_input(line_trigger_input),
    .programmable_mode(programmable_mode),
    .line_trigger_accept(line_trigger_accept),
    .gstat_trig_bits(gstat_trig_bits)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_flags(input logic absent, input logic fail, input logic rate, input logic miss);
    // a failed load means nothing while no image exists
    return {4'h0, miss, rate, fail & ~absent, absent};
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic bus_read(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk);
    req.rd <= 1'h1;
    req.addr <= a;
    @(posedge core_clk);
    req.rd <= 1'h0;
    #1;
    check(name, {24'h0, rdata}, {24'h0, exp});
  endtask

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req.wr <= 1'h1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge core_clk);
    req.wr <= 1'h0;
  endtask

  task automatic trig_pulse(input logic exp);
    @(posedge core_clk);
    line_trigger_input <= 1'h1;
    #1;
    check("trigger_accept", {31'h0, line_trigger_accept}, {31'h0, exp});
    @(posedge core_clk);
    line_trigger_input <= 1'h0;
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin : main
    logic a;
    logic f;
    void'($urandom(14));
    wait_cyc(2);
    reset <= 1'h0;
    bus_read(AVAIL, `LESI_AVAIL_NO, "avail_off");
    inquiry_ready <= 1'h1;
    bus_read(AVAIL, `LESI_AVAIL_YES, "avail_on");
    $display("test availability done");
    trig_pulse(1'h1);
    // first four passes walk every firmware combination, the rest are random
    for (int i = 0; i < 10; i++) begin
      a = (i < 4) ? i[0] : 1'($urandom);
      f = (i < 4) ? i[1] : 1'($urandom);
      fw_image_absent <= a;
      fw_load_failed <= f;
      wait_cyc(2);
      bus_read(FLAGS, exp_flags(a, f, 1'h0, 1'h0), "fw_flags");
      check("gstat_idle", gstat_trig_bits, 32'h0);
      trig_pulse(1'h1);
    end
    fw_image_absent <= 1'h0;
    fw_load_failed <= 1'h0;
    $display("test firmware flags done");
    wait_cyc(MIN_CYC);
    trig_pulse(1'h1);
    trig_pulse(1'h0);
    wait_cyc(2);
    check("gstat_overrun", gstat_trig_bits, GSTAT_SET);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h1, 1'h0), "overrun_flag");
    check("gstat_cleared", gstat_trig_bits, 32'h0);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h0, 1'h0), "overrun_gone");
    wait_cyc(MIN_CYC);
    trig_pulse(1'h1);
    // an overrun that lands on the flag read must survive the clear
    fork
      trig_pulse(1'h0);
      bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h0, 1'h0), "set_on_read");
    join
    check("gstat_set_wins", gstat_trig_bits, GSTAT_SET);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h1, 1'h0), "set_wins_flag");
    $display("test line rate overrun done");
    programmable_mode <= 1'h1;
    wait_cyc(MIN_CYC);
    trig_pulse(1'h1);
    trig_pulse(1'h0);
    wait_cyc(2);
    check("gstat_prog", gstat_trig_bits, 32'h0);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h0, 1'h0), "prog_no_flag");
    programmable_mode <= 1'h0;
    $display("test programmable drop done");
    wait_cyc(TIMEOUT_CYC + 5);
    check("gstat_missing", gstat_trig_bits, GSTAT_SET);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h0, 1'h1), "missing_flag");
    trig_pulse(1'h1);
    wait_cyc(2);
    bus_read(FLAGS, exp_flags(1'h0, 1'h0, 1'h0, 1'h0), "trigger_back");
    $display("test missing trigger done");
    bus_write(FLAGS, 8'hff);
    bus_read(FLAGS + 16'h0001, 8'h00, "unmapped_hi");
    bus_read(AVAIL - 16'h0001, 8'h00, "unmapped_lo");
    bus_read(FLAGS, 8'h00, "after_write");
    a = 1'($urandom);
    inquiry_ready <= a;
    bus_read(AVAIL, a ? `LESI_AVAIL_YES : `LESI_AVAIL_NO, "avail_rand");
    $display("test map and writes done");
    complete_run();
  end

  // the whole sequence takes under two hundred cycles
  initial begin : watchdog
    #(8 * 3000);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule // tb_top

// ===== design/lesi_inquiry.sv
// Purpose: read-only error inquiry bank for the programmable logic
// Assumes: byte register port, read data one cycle after the strobe
// Notes: flag read also clears the trigger summary in general status
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "lesi_params.svh"

// Functional notes
// - bank sits at base address 0x0c10
// - offset 0 reads availability, 0x00 or 0x01
// - offset 1 reads error flags, bit0 lowest
// - bit 0 set when firmware image absent
// - bit 1 set when firmware load failed with an image present
// - bit 2 set on line rate overrun
// - programmable mode drops fast triggers, no flag
// - bit 3 set while line trigger absent
// - flag read clears general status bit 17
module lesi_inquiry #(
  parameter int MIN_CYC = `LESI_MIN_LINE_CYC,
  parameter int TIMEOUT_CYC = `LESI_TRIG_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire lesi_pkg::lesi_req_s req,
  output logic [7:0] rdata,
  input wire logic inquiry_ready,
  input wire logic fw_image_absent,
  input wire logic fw_load_failed,
  input wire logic line_trigger_input,
  input wire logic programmable_mode,
  output logic line_trigger_accept,
  output logic [31:0] gstat_trig_bits
);
  import lesi_pkg::*;

  lesi_flags_s flags;
  logic trig_summary;
  logic [7:0] next_rdata;
  lesi_flags_s next_flags;
  logic next_trig_summary;
  logic trig_overrun;
  logic trig_missing;
  logic missing_q;
  logic next_missing_q;
  logic hit_avail;
  logic hit_flags;

  // ------------------------------------------------------------
  // trigger monitor
  // ------------------------------------------------------------
  lesi_trig_monitor #(
    .MIN_CYC(MIN_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_mon (
    .core_clk(core_clk),
    .reset(reset),
    .line_trigger_input(line_trigger_input),
    .programmable_mode(programmable_mode),
    .trig_accept(line_trigger_accept),
    .trig_overrun(trig_overrun),
    .trig_missing(trig_missing)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // only the two bytes of the bank answer, so a neighbouring bank is never aliased
  always_comb begin
    hit_avail = req.rd && (req.addr == (`LESI_BASE_ADDR + `LESI_OFS_AVAIL));
    hit_flags = req.rd && (req.addr == (`LESI_BASE_ADDR + `LESI_OFS_FLAGS));
  end

  // ------------------------------------------------------------
  // error flags
  // ------------------------------------------------------------
  always_comb begin
    next_flags = flags;
    next_flags.no_fw = fw_image_absent;
    // a failed load means nothing while no image exists, so it is masked
    next_flags.load_fail = fw_load_failed & ~fw_image_absent;
    next_flags.no_trig = trig_missing;
    next_flags.reserved = 4'h0;
    // overrun is an event, so it is held until software has seen it
    if (trig_overrun) begin
      next_flags.rate_over = 1'b1;
    end else if (hit_flags) begin
      next_flags.rate_over = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // ------------------------------------------------------------
  // trigger summary for the general status word
  // ------------------------------------------------------------
  always_comb begin
    next_missing_q = trig_missing;
    // set beats the clear so an error landing on the read is kept
    if (trig_overrun || (trig_missing && !missing_q)) begin
      next_trig_summary = 1'b1;
    end else if (hit_flags) begin
      next_trig_summary = 1'b0;
    end else begin
      next_trig_summary = trig_summary;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trig_summary <= 1'b0;
      missing_q <= 1'b0;
    end else begin
      trig_summary <= next_trig_summary;
      missing_q <= next_missing_q;
    end
  end

  // only the trigger summary is owned here, the other status bits stay zero
  always_comb begin
    gstat_trig_bits = 32'h0000_0000;
    gstat_trig_bits[`LESI_GSTAT_TRIG_BIT] = trig_summary;
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb begin
    // writes and unmapped reads are answered with zero
    if (hit_avail) begin
      next_rdata = inquiry_ready ? `LESI_AVAIL_YES : `LESI_AVAIL_NO;
    end else if (hit_flags) begin
      next_rdata = flags;
    end else begin
      next_rdata = `LESI_RDATA_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  base_decode_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && (req.addr < `LESI_BASE_ADDR || req.addr > (`LESI_BASE_ADDR + `LESI_OFS_FLAGS))
      |=> rdata == 8'h00)
    else $error("read outside bank returned data");
  avail_read_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr == 16'h0c10 |=> rdata == {7'h00, $past(inquiry_ready)})
    else $error("availability field wrong");
  flags_read_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr == 16'h0c11 |=> rdata == $past(flags))
    else $error("flag field read mismatch");
  no_fw_a: assert property (@(posedge core_clk) disable iff (reset)
    fw_image_absent ##1 req.rd && req.addr == 16'h0c11 |=> rdata[0])
    else $error("missing firmware not flagged");
  load_fail_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 flags.load_fail == $past(fw_load_failed & ~fw_image_absent))
    else $error("load failure flag wrong");
  rate_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    trig_overrun |=> flags.rate_over ##1 (flags.rate_over || $past(hit_flags)))
    else $error("overrun flag lost before read");
  missing_a: assert property (@(posedge core_clk) disable iff (reset)
    trig_missing |=> flags.no_trig)
    else $error("missing trigger not flagged");
  summary_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    hit_flags && !trig_overrun && !(trig_missing && !missing_q) |=> !gstat_trig_bits[17])
    else $error("summary not cleared by flag read");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr == 16'h0c11 |=> rdata[7:4] == 4'h0)
    else $error("reserved flag bits not zero");
  prog_no_over_a: assert property (@(posedge core_clk) disable iff (reset)
    programmable_mode && !flags.rate_over |=> !flags.rate_over)
    else $error("overrun flag set in programmable mode");
  idle_rdata_a: assert property (@(posedge core_clk) disable iff (reset)
    !req.rd |=> rdata == 8'h00)
    else $error("read data not idle without a read");
  write_ignored_a: assert property (@(posedge core_clk) disable iff (reset)
    req.wr && !req.rd && !trig_overrun |=> flags.rate_over == $past(flags.rate_over))
    else $error("write changed a read-only flag");
  gstat_unused_a: assert property (@(posedge core_clk) disable iff (reset)
    gstat_trig_bits[31:18] == 14'h0000 && gstat_trig_bits[16:0] == 17'h0_0000)
    else $error("unowned general status bits not zero");
  summary_set_a: assert property (@(posedge core_clk) disable iff (reset)
    trig_overrun |=> gstat_trig_bits[17])
    else $error("overrun not raised in trigger summary");
  rate_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    hit_flags && !trig_overrun |=> !flags.rate_over)
    else $error("overrun flag kept after flag read");
  load_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    fw_image_absent |=> !flags.load_fail)
    else $error("load failure flagged without an image");
  no_fw_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    !fw_image_absent |=> !flags.no_fw)
    else $error("missing firmware flagged while present");
  missing_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    !trig_missing |=> !flags.no_trig)
    else $error("missing trigger flagged while present");
  accept_excl_a: assert property (@(posedge core_clk) disable iff (reset)
    !(line_trigger_accept && trig_overrun))
    else $error("overrun edge also accepted as trigger");

  overrun_seen_c: cover property (@(posedge core_clk) disable iff (reset)
    trig_overrun ##[1:4] hit_flags);
  missing_seen_c: cover property (@(posedge core_clk) disable iff (reset)
    trig_missing && !missing_q);
  set_on_clear_c: cover property (@(posedge core_clk) disable iff (reset)
    trig_overrun && hit_flags);
  avail_read_c: cover property (@(posedge core_clk) disable iff (reset)
    hit_avail && inquiry_ready);
  prog_drop_c: cover property (@(posedge core_clk) disable iff (reset)
    programmable_mode && $rose(line_trigger_input) && !line_trigger_accept);
endmodule // lesi_inquiry

// ===== design/lesi_params.svh
// Purpose: constants of the logic error status inquiry bank
// Assumes: 125 MHz core clock, byte-wide register port
// Notes: definitions only
`ifndef LESI_PARAMS_SVH
`define LESI_PARAMS_SVH

// ------------------------------------------------------------
// address map
// ------------------------------------------------------------
`define LESI_BASE_ADDR 16'h0c10
`define LESI_OFS_AVAIL 16'h0000
`define LESI_OFS_FLAGS 16'h0001
`define LESI_AVAIL_NO 8'h00
`define LESI_AVAIL_YES 8'h01
`define LESI_RDATA_IDLE 8'h00

// ------------------------------------------------------------
// flag bit positions
// ------------------------------------------------------------
`define LESI_BIT_NO_FW 0
`define LESI_BIT_LOAD_FAIL 1
`define LESI_BIT_RATE_OVER 2
`define LESI_BIT_NO_TRIG 3
`define LESI_GSTAT_TRIG_BIT 17

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LESI_CLK_NS 8
`define LESI_MIN_LINE_NS 1000
`define LESI_MIN_LINE_CYC ((`LESI_MIN_LINE_NS + `LESI_CLK_NS - 1) / `LESI_CLK_NS)
`define LESI_TRIG_TIMEOUT_US 1000
`define LESI_TRIG_TIMEOUT_CYC ((`LESI_TRIG_TIMEOUT_US * 1000) / `LESI_CLK_NS)

`endif

// ===== design/lesi_pkg.sv
// Purpose: shared types of the logic error status inquiry bank
// Assumes: constants live in lesi_params.svh
// Notes: none
package lesi_pkg;

  // ------------------------------------------------------------
  // register port request
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lesi_req_s;

  // ------------------------------------------------------------
  // error flag field layout, bit 0 lowest
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] reserved;
    logic no_trig;
    logic rate_over;
    logic load_fail;
    logic no_fw;
  } lesi_flags_s;

  typedef enum logic {
    LESI_TRIG_WAIT_FIRST,
    LESI_TRIG_RUNNING
  } lesi_trig_e;

endpackage

// ===== design/lesi_trig_monitor.sv
// Purpose: watches the line trigger input for overrun and absence
// Assumes: line_trigger_input synchronous to core_clk
// Notes: gap counter saturates, so a dead input stays flagged
`timescale 1ns/1ps
`include "lesi_params.svh"

module lesi_trig_monitor #(
  parameter int MIN_CYC = `LESI_MIN_LINE_CYC,
  parameter int TIMEOUT_CYC = `LESI_TRIG_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic line_trigger_input,
  input wire logic programmable_mode,
  output logic trig_accept,
  output logic trig_overrun,
  output logic trig_missing
);
  import lesi_pkg::*;

  logic prev_in;
  logic [31:0] gap_cnt;
  lesi_trig_e state;
  logic next_prev_in;
  logic [31:0] next_gap_cnt;
  lesi_trig_e next_state;
  logic rise;
  logic too_fast;

  // ------------------------------------------------------------
  // trigger qualification
  // ------------------------------------------------------------
  always_comb begin
    rise = line_trigger_input & ~prev_in;
    too_fast = (state == LESI_TRIG_RUNNING) && (gap_cnt < 32'(MIN_CYC));
    next_prev_in = line_trigger_input;
    next_state = state;
    // a discarded pulse does not restart the gap, it never happened
    // a fast edge is never accepted: dropped in programmable mode, an overrun otherwise
    trig_accept = rise & ~too_fast;
    trig_overrun = rise & too_fast & ~programmable_mode;
    if (trig_accept || trig_overrun) begin
      next_gap_cnt = 32'h0000_0000;
      next_state = LESI_TRIG_RUNNING;
    end else if (gap_cnt != 32'hffff_ffff) begin
      next_gap_cnt = gap_cnt + 32'h0000_0001;
    end else begin
      next_gap_cnt = gap_cnt;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_in <= 1'b0;
      gap_cnt <= 32'h0000_0000;
      state <= LESI_TRIG_WAIT_FIRST;
    end else begin
      prev_in <= next_prev_in;
      gap_cnt <= next_gap_cnt;
      state <= next_state;
    end
  end

  assign trig_missing = (gap_cnt >= 32'(TIMEOUT_CYC));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  discard_no_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    programmable_mode |-> !trig_overrun)
    else $error("overrun raised in programmable trigger mode");
  // an edge two cycles after a trigger is always too fast while MIN_CYC is above 1
  overrun_spacing_a: assert property (@(posedge core_clk) disable iff (reset)
    (trig_accept || trig_overrun) ##2
      (line_trigger_input && !$past(line_trigger_input) && !programmable_mode) |-> trig_overrun)
    else $error("fast trigger not reported as overrun");
endmodule // lesi_trig_monitor
